// ---- sim/pcx_pin_env.sv ----
// file: outside circuitry that resolves each port pin level
`timescale 1ns/1ps
module pcx_pin_env
  import pcx_pkg::*;
(
  // clock
  input wire logic clock,
  // crossbar pin control
  input wire logic [PCX_NPIN-1:0] pin_out,
  input wire logic [PCX_NPIN-1:0] pin_oe,
  input wire logic [PCX_NPIN-1:0] pin_pullup_en,
  // outside drivers
  input wire logic [PCX_NPIN-1:0] ext_en,
  input wire logic [PCX_NPIN-1:0] ext_val,
  // resolved levels
  output logic [PCX_NPIN-1:0] pin_in
);
  logic [PCX_NPIN-1:0] float_ff = 20'h00000;
  // a floating pin wanders, so a stale level never passes for a driven one
  always @(posedge clock) float_ff <= ~float_ff;
  always_comb begin
    for (int i = 0; i < PCX_NPIN; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i]) pin_in[i] = 1'h1;
      else pin_in[i] = float_ff[i];
    end
  end
endmodule : pcx_pin_env

// ---- sim/port_crossbar_pin_assignment_tb.sv ----
// file: self-checking bench of the port crossbar
`timescale 1ns/1ps
module port_crossbar_pin_assignment_tb
  import pcx_pkg::*;
;
  typedef struct {int kind; logic [32:0] exp;} pcx_note_t;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, snap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] func_out, func_oe, func_in;
  logic [19:0] port_latch, port_read, pin_in, pin_out, pin_oe, pin_pullup_en, pin_rx_en;
  logic [19:0] ext_en, ext_val, lat;
  logic [32:0] seen;
  pcx_note_t q[$];
  pcx_note_t cur;
  int tests_run = 0;
  int bad_count = 0;
  string names [7] = '{"apb", "pin_oe", "pin_out", "pullup", "rx_en", "func_in", "port_read"};
  pcx_func_t cmp_fn [3:7] = '{FN_SYSCK, FN_CP0, FN_CP0A, FN_CP1, FN_CP1A};

  pcx_crossbar DUT (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .func_out(func_out), .func_oe(func_oe), .func_in(func_in),
    .port_latch(port_latch), .port_read(port_read), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_rx_en(pin_rx_en));
  pcx_pin_env env (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  always #10 clock = ~clock;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic note(input int k, input logic [32:0] e);
    q.push_back('{k, e});
  endtask : note

  // pin state settles two edges after a write; four leaves margin for func_in
  task automatic look();
    repeat (4) @(posedge clock);
    snap <= 1'h1;
    @(posedge clock);
    snap <= 1'h0;
    // quiet edge: new notes never race the watcher's snapshot edge
    @(posedge clock);
  endtask : look

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        tally_and_finish();
      end
      @(posedge clock);
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    note(0, {err, e});
    apb(1'h0, a, 32'h0);
  endtask : rd

  // watcher: every answer or snapshot retires every queued note
  always @(posedge clock) begin
    if (pready === 1'h1 || snap === 1'h1) begin
      while (q.size() > 0) begin
        cur = q.pop_front();
        case (cur.kind)
          0: seen = {pslverr, prdata};
          1: seen = {13'h0, pin_oe};
          2: seen = {13'h0, pin_out};
          3: seen = {13'h0, pin_pullup_en};
          4: seen = {13'h0, pin_rx_en};
          5: seen = {20'h0, func_in};
          default: seen = {13'h0, port_read};
        endcase
        tests_run++;
        if (seen !== cur.exp) begin
          bad_count++;
          $display("mismatch %s expected %h seen %h", names[cur.kind], cur.exp, seen);
        end
      end
    end
  end

  initial begin
    clock = 1'h0;
    srst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    snap = 1'h0;
    func_out = 13'h0;
    func_oe = 13'h0;
    port_latch = 20'hFFFFF;
    ext_en = 20'h0;
    ext_val = 20'h0;
    lat = 20'($urandom(26));
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    note(1, 33'h0);
    note(4, 33'hFFFFF);
    note(3, 33'hFFFFF);
    note(5, 33'h1FFF);
    look();
    rd(PCX_ADDR_ROUTE0, 32'h0, 1'h0);
    rd(PCX_ADDR_ROUTE1, 32'h0, 1'h0);
    rd(PCX_ADDR_INMODE, 32'hFFFFF, 1'h0);
    rd(12'hFFC, 32'h0, 1'h1);
    // routing chosen while the crossbar is still off
    apb(1'h1, PCX_ADDR_ROUTE0, 32'hFF);
    apb(1'h1, PCX_ADDR_OUTMODE, 32'hFFFFF);
    note(1, 33'h0);
    note(5, 33'h1FFF);
    look();
    rd(PCX_ADDR_CLAIMED, 32'h0, 1'h0);
    rd(PCX_ADDR_ROUTE0, 32'hFF, 1'h0);
    // serial pair lands on its fixed pins even when those are skipped
    apb(1'h1, PCX_ADDR_OUTMODE, 32'h0);
    apb(1'h1, PCX_ADDR_SKIP, 32'h30);
    apb(1'h1, PCX_ADDR_ROUTE0, 32'h01);
    apb(1'h1, PCX_ADDR_ROUTE1, 32'h40);
    ext_en <= 20'h00020;
    ext_val <= lat;
    func_oe <= 13'h1 << FN_TX;
    func_out <= 13'h0;
    note(1, 33'h10);
    note(3, 33'hFFFEF);
    note(5, {20'h0, 11'h7FF, lat[5], 1'h0});
    look();
    rd(PCX_ADDR_CLAIMED, 32'h30, 1'h0);
    ext_en <= 20'h0;
    apb(1'h1, PCX_ADDR_SKIP, 32'h0);
    apb(1'h1, PCX_ADDR_ROUTE0, 32'h07);
    rd(PCX_ADDR_CLAIMED, 32'h7F, 1'h0);
    apb(1'h1, PCX_ADDR_SSMODE, 32'h1);
    rd(PCX_ADDR_CLAIMED, 32'hFF, 1'h0);
    // two-wire needs two free pins or takes none
    apb(1'h1, PCX_ADDR_ROUTE0, 32'h04);
    apb(1'h1, PCX_ADDR_SKIP, 32'hFFEFF);
    rd(PCX_ADDR_CLAIMED, 32'h0, 1'h0);
    apb(1'h1, PCX_ADDR_SKIP, 32'hFFCFF);
    rd(PCX_ADDR_CLAIMED, 32'h300, 1'h0);
    apb(1'h1, PCX_ADDR_SKIP, 32'h0);
    for (int i = 3; i < 8; i++) begin
      apb(1'h1, PCX_ADDR_ROUTE0, 32'h1 << i);
      func_oe <= 13'h1 << cmp_fn[i];
      note(1, 33'h1);
      note(3, 33'hFFFFE);
      look();
    end
    // two-wire stays open-drain although every pin asks for push-pull
    lat = 20'($urandom);
    port_latch <= lat;
    apb(1'h1, PCX_ADDR_OUTMODE, 32'hFFFFF);
    apb(1'h1, PCX_ADDR_ROUTE0, 32'h04);
    func_oe <= 13'h1 << FN_SDA;
    func_out <= 13'h1FFF;
    note(1, 33'hFFFFC);
    note(2, 33'(lat & 20'hFFFFC));
    note(3, 33'h3);
    look();
    apb(1'h1, PCX_ADDR_ROUTE1, 32'hC0);
    note(3, 33'h0);
    look();
    // analog pin, skipped as software should
    apb(1'h1, PCX_ADDR_INMODE, 32'hFFBFF);
    apb(1'h1, PCX_ADDR_OUTMODE, 32'h0);
    apb(1'h1, PCX_ADDR_SKIP, 32'h400);
    apb(1'h1, PCX_ADDR_ROUTE0, 32'h0);
    apb(1'h1, PCX_ADDR_ROUTE1, 32'h40);
    note(1, 33'(~lat & 20'hFFBFF));
    note(3, 33'(lat & 20'hFFBFF));
    note(4, 33'hFFBFF);
    note(6, 33'(lat & 20'hFFBFF));
    look();
    tally_and_finish();
  end
endmodule : port_crossbar_pin_assignment_tb

// ---- src/pcx_alloc.sv ----
// file: priority allocator of crossbar functions to port pins
`timescale 1ns/1ps
module pcx_alloc
  import pcx_pkg::*;
#(
  parameter int NPIN = PCX_NPIN,
  parameter int NFUNC = PCX_NFUNC
) (
  // requests
  input wire logic [NFUNC-1:0] sel,
  input wire logic [NPIN-1:0] skip,
  // result
  output logic [NPIN-1:0][3:0] asg
);
  localparam int IW = $clog2(NPIN);

  // returns {found, index} of the lowest pin not yet used
  function automatic logic [IW:0] first_free(input logic [NPIN-1:0] used);
    logic [IW:0] r;
    r = '0;
    for (int p = NPIN - 1; p >= 0; p--) begin
      if (!used[p]) begin
        r = {1'h1, p[IW-1:0]};
      end
    end
    return r;
  endfunction : first_free

  logic [NPIN-1:0] used;
  logic [IW:0] a;
  logic [IW:0] b;

  always_comb begin
    used = skip;
    a = '0;
    b = '0;
    for (int p = 0; p < NPIN; p++) begin
      asg[p] = FN_GPIO;
    end
    // serial port pins are fixed, whatever the skip bits say
    if (sel[FN_TX]) begin
      asg[PCX_TX_PIN] = FN_TX;
      asg[PCX_RX_PIN] = FN_RX;
      used[PCX_TX_PIN] = 1'h1;
      used[PCX_RX_PIN] = 1'h1;
    end
    for (int f = FN_SCK; f < NFUNC; f++) begin
      if (sel[f] && f != FN_SCL) begin
        a = first_free(used);
        if (f == FN_SDA) begin
          b = first_free(used | (NPIN'(1) << a[IW-1:0]));
          // a lone free pin is left alone rather than half a bus
          if (a[IW] && b[IW]) begin
            asg[a[IW-1:0]] = FN_SDA;
            asg[b[IW-1:0]] = FN_SCL;
            used[a[IW-1:0]] = 1'h1;
            used[b[IW-1:0]] = 1'h1;
          end
        end else if (a[IW]) begin
          asg[a[IW-1:0]] = f[3:0];
          used[a[IW-1:0]] = 1'h1;
        end
      end
    end
  end
endmodule : pcx_alloc

// ---- src/pcx_crossbar.sv ----
// file: port crossbar top with APB register slave and pin drive logic
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module pcx_crossbar
  import pcx_pkg::*;
#(
  parameter int NPIN = PCX_NPIN
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PCX_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral side, indexed by function code
  input wire logic [PCX_NFUNC-1:0] func_out,
  input wire logic [PCX_NFUNC-1:0] func_oe,
  output logic [PCX_NFUNC-1:0] func_in,
  // port latches and port read value
  input wire logic [NPIN-1:0] port_latch,
  output logic [NPIN-1:0] port_read,
  // pins
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pin_pullup_en,
  output logic [NPIN-1:0] pin_rx_en
);
  typedef struct packed {
    logic [7:0] route0;
    logic wpud;
    logic xen;
    logic [NPIN-1:0] inmode;
    logic [NPIN-1:0] outmode;
    logic [NPIN-1:0] skip;
    logic [1:0] ssmode;
    logic [NPIN-1:0][3:0] asg;
    logic [NPIN-1:0] pout;
    logic [NPIN-1:0] poe;
    logic [NPIN-1:0] ppu;
    logic [NPIN-1:0] prx;
    logic [NPIN-1:0] rd;
    logic [PCX_NFUNC-1:0] fin;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } pcx_state_t;

  pcx_state_t st_ff;
  pcx_state_t nxt_st;

  function automatic pcx_rsel_t reg_decode(input logic [PCX_AW-1:0] a);
    pcx_rsel_t r;
    r = RS_NONE;
    unique case (a)
      PCX_ADDR_ROUTE0: r = RS_ROUTE0;
      PCX_ADDR_ROUTE1: r = RS_ROUTE1;
      PCX_ADDR_INMODE: r = RS_INMODE;
      PCX_ADDR_OUTMODE: r = RS_OUTMODE;
      PCX_ADDR_SKIP: r = RS_SKIP;
      PCX_ADDR_SSMODE: r = RS_SSMODE;
      PCX_ADDR_CLAIMED: r = RS_CLAIMED;
      default: r = RS_NONE;
    endcase
    return r;
  endfunction : reg_decode

  // routing requests and per-pin sources
  logic [PCX_NFUNC-1:0] sel_raw;
  logic [PCX_NFUNC-1:0] sel;
  logic [NPIN-1:0][3:0] asg_w;
  logic [NPIN-1:0] claimed;
  logic [NPIN-1:0] smb;
  logic [NPIN-1:0] src_val;
  logic [NPIN-1:0] src_en;
  logic [NPIN-1:0] cell_out;
  logic [NPIN-1:0] cell_oe;
  logic [NPIN-1:0] cell_pu;
  logic [NPIN-1:0] cell_rx;
  // bus
  logic acc;
  logic done;
  pcx_rsel_t rsel;

  always_comb begin
    sel_raw = '0;
    sel_raw[FN_TX] = st_ff.route0[PCX_B_SERIAL];
    sel_raw[FN_RX] = st_ff.route0[PCX_B_SERIAL];
    sel_raw[FN_SCK] = st_ff.route0[PCX_B_SPI];
    sel_raw[FN_MISO] = st_ff.route0[PCX_B_SPI];
    sel_raw[FN_MOSI] = st_ff.route0[PCX_B_SPI];
    // three-wire mode leaves slave select off the pins
    sel_raw[FN_NSS] = st_ff.route0[PCX_B_SPI] & (st_ff.ssmode != 2'h0);
    sel_raw[FN_SDA] = st_ff.route0[PCX_B_TWOWIRE];
    sel_raw[FN_SCL] = st_ff.route0[PCX_B_TWOWIRE];
    sel_raw[FN_CP0] = st_ff.route0[PCX_B_CP0];
    sel_raw[FN_CP0A] = st_ff.route0[PCX_B_CP0A];
    sel_raw[FN_CP1] = st_ff.route0[PCX_B_CP1];
    sel_raw[FN_CP1A] = st_ff.route0[PCX_B_CP1A];
    sel_raw[FN_SYSCK] = st_ff.route0[PCX_B_SYSCK];
    // routing choices count only once the crossbar is on
    sel = st_ff.xen ? sel_raw : '0;
  end

  pcx_alloc #(
    .NPIN(NPIN),
    .NFUNC(PCX_NFUNC)
  ) u_alloc (
    .sel(sel),
    .skip(st_ff.skip),
    .asg(asg_w)
  );

  // sources follow the registered mapping, one cycle behind the settings
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      claimed[p] = (st_ff.asg[p] != FN_GPIO);
      smb[p] = (st_ff.asg[p] == FN_SDA) || (st_ff.asg[p] == FN_SCL);
      if (claimed[p] && st_ff.asg[p] < PCX_NFUNC) begin
        src_val[p] = func_out[st_ff.asg[p]];
        src_en[p] = func_oe[st_ff.asg[p]];
      end else begin
        src_val[p] = port_latch[p];
        src_en[p] = 1'h1;
      end
    end
  end

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    pcx_pin_cell u_cell (
      .xen(st_ff.xen),
      .digital(st_ff.inmode[g]),
      .push_pull(st_ff.outmode[g]),
      .force_od(smb[g]),
      .wpud(st_ff.wpud),
      .src_val(src_val[g]),
      .src_en(src_en[g]),
      .out_val(cell_out[g]),
      .out_en(cell_oe[g]),
      .pull_en(cell_pu[g]),
      .rx_en(cell_rx[g])
    );
  end

  assign acc = psel & penable;
  assign done = acc & st_ff.rdy;
  assign rsel = reg_decode(paddr);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.asg = asg_w;
    nxt_st.pout = cell_out;
    nxt_st.poe = cell_oe;
    nxt_st.ppu = cell_pu;
    nxt_st.prx = cell_rx;
    // analog pins read zero since their receiver is off
    nxt_st.rd = pin_in & st_ff.inmode;
    for (int f = 0; f < PCX_NFUNC; f++) begin
      nxt_st.fin[f] = 1'h1;
      for (int p = 0; p < NPIN; p++) begin
        if (st_ff.asg[p] == f[3:0]) begin
          nxt_st.fin[f] = pin_in[p] & st_ff.inmode[p];
        end
      end
    end
    // one wait state: answer is raised in the second access cycle
    nxt_st.rdy = acc & ~st_ff.rdy;
    nxt_st.err = 1'h0;
    nxt_st.rdata = '0;
    if (acc && !st_ff.rdy) begin
      nxt_st.err = (rsel == RS_NONE);
      if (!pwrite) begin
        unique case (rsel)
          RS_ROUTE0: nxt_st.rdata[7:0] = st_ff.route0;
          RS_ROUTE1: begin
            nxt_st.rdata[PCX_B_WPUD] = st_ff.wpud;
            nxt_st.rdata[PCX_B_XEN] = st_ff.xen;
          end
          RS_INMODE: nxt_st.rdata[NPIN-1:0] = st_ff.inmode;
          RS_OUTMODE: nxt_st.rdata[NPIN-1:0] = st_ff.outmode;
          RS_SKIP: nxt_st.rdata[NPIN-1:0] = st_ff.skip;
          RS_SSMODE: nxt_st.rdata[1:0] = st_ff.ssmode;
          RS_CLAIMED: nxt_st.rdata[NPIN-1:0] = claimed;
          RS_NONE: nxt_st.rdata = '0;
        endcase
      end
    end
    if (done && pwrite) begin
      unique case (rsel)
        RS_ROUTE0: nxt_st.route0 = pwdata[7:0];
        RS_ROUTE1: begin
          nxt_st.wpud = pwdata[PCX_B_WPUD];
          nxt_st.xen = pwdata[PCX_B_XEN];
        end
        RS_INMODE: nxt_st.inmode = pwdata[NPIN-1:0];
        RS_OUTMODE: nxt_st.outmode = pwdata[NPIN-1:0];
        RS_SKIP: nxt_st.skip = pwdata[NPIN-1:0];
        RS_SSMODE: nxt_st.ssmode = pwdata[1:0];
        RS_CLAIMED: nxt_st.route0 = st_ff.route0;
        RS_NONE: nxt_st.route0 = st_ff.route0;
      endcase
    end
    if (srst) begin
      nxt_st = '0;
      nxt_st.route0 = PCX_RST_ROUTE0;
      nxt_st.wpud = PCX_RST_WPUD;
      nxt_st.xen = PCX_RST_XEN;
      nxt_st.inmode = PCX_RST_INMODE;
      nxt_st.outmode = PCX_RST_OUTMODE;
      nxt_st.skip = PCX_RST_SKIP;
      nxt_st.ssmode = PCX_RST_SSMODE;
      nxt_st.prx = PCX_RST_INMODE;
      for (int p = 0; p < NPIN; p++) begin
        nxt_st.asg[p] = FN_GPIO;
      end
      nxt_st.fin = '1;
    end
  end

  always_ff @(posedge clock) begin
    st_ff <= nxt_st;
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign func_in = st_ff.fin;
  assign port_read = st_ff.rd;
  assign pin_out = st_ff.pout;
  assign pin_oe = st_ff.poe;
  assign pin_pullup_en = st_ff.ppu;
  assign pin_rx_en = st_ff.prx;

  // helpers read only by the checks below
  logic [NPIN-1:0] chk_sda;
  logic [NPIN-1:0] chk_scl;
  logic [NPIN-1:0] chk_nss;
  logic [NPIN-1:0] chk_free;
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      chk_sda[p] = (st_ff.asg[p] == FN_SDA);
      chk_scl[p] = (st_ff.asg[p] == FN_SCL);
      chk_nss[p] = (st_ff.asg[p] == FN_NSS);
      chk_free[p] = claimed[p] && p != PCX_TX_PIN && p != PCX_RX_PIN;
    end
  end

  chk_serial_fixed: assert property (
    @(posedge clock) disable iff (srst)
    st_ff.xen && st_ff.route0[PCX_B_SERIAL]
    |=> st_ff.asg[PCX_TX_PIN] == FN_TX && st_ff.asg[PCX_RX_PIN] == FN_RX)
    else $error("serial lines not on their fixed pins");

  chk_twowire_pair: assert property (
    @(posedge clock) disable iff (srst)
    $countones(chk_sda) == $countones(chk_scl))
    else $error("two-wire data and clock not claimed together");

  chk_disabled_drive: assert property (
    @(posedge clock) disable iff (srst)
    !st_ff.xen |=> st_ff.poe == '0 && claimed == '0)
    else $error("driver on or pin claimed with crossbar off");

  chk_analog_off: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> ((st_ff.poe | st_ff.ppu | st_ff.prx) & ~$past(st_ff.inmode)) == '0)
    else $error("analog pin has driver, pullup or receiver on");

  chk_nss_wires: assert property (
    @(posedge clock) disable iff (srst)
    st_ff.ssmode == 2'h0 |=> chk_nss == '0)
    else $error("slave select pinned in three-wire mode");

  chk_twowire_od: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> (st_ff.pout & $past(chk_sda | chk_scl)) == '0)
    else $error("two-wire pin driven high");

  chk_pullup_low: assert property (
    @(posedge clock) disable iff (srst)
    (st_ff.poe & ~st_ff.pout & st_ff.ppu) == '0)
    else $error("pullup on while pin drives low");

  chk_skip_kept: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> (chk_free & $past(st_ff.skip)) == '0)
    else $error("skipped pin given to a function");

  chk_reset_digital: assert property (
    @(posedge clock) disable iff (srst)
    $fell(srst) |-> st_ff.inmode == PCX_RST_INMODE && !st_ff.xen)
    else $error("pins not digital inputs after reset");

  chk_route_write: assert property (
    @(posedge clock) disable iff (srst)
    done && pwrite && rsel == RS_ROUTE0 |=> st_ff.route0 == $past(pwdata[7:0]))
    else $error("route register write lost");

  chk_pp_only: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> (st_ff.pout & ~$past(st_ff.outmode)) == '0)
    else $error("open-drain pin driven high");

  chk_pullup_pp: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> (st_ff.ppu & $past(st_ff.outmode & ~(chk_sda | chk_scl))) == '0)
    else $error("pullup on a push-pull pin");

  chk_pullup_off: assert property (
    @(posedge clock) disable iff (srst)
    st_ff.wpud |=> st_ff.ppu == '0)
    else $error("pullup on while pullups disabled");

  chk_gpio_latch: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> ((st_ff.pout ^ $past(port_latch)) & $past(~claimed & st_ff.outmode)) == '0)
    else $error("free push-pull pin not showing its latch");

  chk_rx_mode: assert property (
    @(posedge clock) disable iff (srst)
    1'h1 |=> st_ff.prx == $past(st_ff.inmode))
    else $error("receiver enable differs from input mode");

  chk_serial_pair: assert property (
    @(posedge clock) disable iff (srst)
    (st_ff.asg[PCX_TX_PIN] == FN_TX) == (st_ff.asg[PCX_RX_PIN] == FN_RX))
    else $error("serial transmit and receive not claimed together");

  chk_off_inputs: assert property (
    @(posedge clock) disable iff (srst)
    !st_ff.xen && claimed == '0 |=> st_ff.fin == '1)
    else $error("function input fed from a pin with crossbar off");

  chk_unmapped_err: assert property (
    @(posedge clock) disable iff (srst)
    acc && !st_ff.rdy && rsel == RS_NONE |=> st_ff.err && st_ff.rdata == '0)
    else $error("unmapped access not answered with an error");

  // a lone pulse keeps a stalled master from taking two answers
  chk_answer_once: assert property (
    @(posedge clock) disable iff (srst)
    st_ff.rdy |=> !st_ff.rdy)
    else $error("bus answer held longer than one cycle");
endmodule : pcx_crossbar

// ---- src/pcx_pin_cell.sv ----
// file: driver, pullup and receiver control of one port pin
`timescale 1ns/1ps
module pcx_pin_cell (
  // mode
  input wire logic xen,
  input wire logic digital,
  input wire logic push_pull,
  input wire logic force_od,
  input wire logic wpud,
  // source
  input wire logic src_val,
  input wire logic src_en,
  // pin control
  output logic out_val,
  output logic out_en,
  output logic pull_en,
  output logic rx_en
);
  logic od;
  logic drv;
  // driver type from the mode bit only, two-wire lines forced open-drain
  assign od = ~push_pull | force_od;
  // analog or disabled crossbar: driver off
  assign drv = xen & digital & src_en;
  assign out_en = drv & (~od | ~src_val);
  assign out_val = ~od & src_val;
  // no pullup on analog pins or while pulling low, saves sink current
  assign pull_en = digital & od & ~wpud & ~(drv & ~src_val);
  assign rx_en = digital;
endmodule : pcx_pin_cell

// ---- src/pcx_pkg.sv ----
// package: register map, field layout and function codes of the port crossbar
// Summary of operation
// - two-wire routing claims its data and clock pins together, or neither
// - serial port routing claims transmit and receive pins as one pair
// - serial transmit sits on P0.4, receive on P0.5, always
// - pins left unclaimed behave as general-purpose port pins
// - slave select gets a pin only in four-wire SPI mode
// - analog pin has pullup, output driver and input receiver all off
// - input mode bit 1 means digital, 0 analog; reset gives digital
// - output driver type comes from the per-pin output mode bit, except on two-wire pins
// - two-wire data and clock pins always drive open-drain
// - weak pullup on open-drain pins while pullup disable is 0
// - weak pullup off while the pin drives low
// - crossbar disabled means all pins stay port pins in input mode
// - crossbar disabled turns every output driver off
// - route register bits 7..4 select comparator async and sync outputs
// - route register bits 2, 1, 0 enable two-wire, SPI, serial port
// - each selected function but the serial port takes the lowest free, unskipped pin
package pcx_pkg;
  localparam int PCX_NPIN = 20;
  localparam int PCX_NFUNC = 13;
  localparam int PCX_AW = 12;
  // printed offsets are register indexes; byte address is four times that
  localparam logic [PCX_AW-1:0] PCX_ROUTE0_IDX = 12'h0E1;
  localparam logic [PCX_AW-1:0] PCX_ROUTE1_IDX = 12'h0E2;
  localparam logic [PCX_AW-1:0] PCX_ADDR_ROUTE0 = {PCX_ROUTE0_IDX[PCX_AW-3:0], 2'h0};
  localparam logic [PCX_AW-1:0] PCX_ADDR_ROUTE1 = {PCX_ROUTE1_IDX[PCX_AW-3:0], 2'h0};
  localparam logic [PCX_AW-1:0] PCX_ADDR_INMODE = 12'h000;
  localparam logic [PCX_AW-1:0] PCX_ADDR_OUTMODE = 12'h004;
  localparam logic [PCX_AW-1:0] PCX_ADDR_SKIP = 12'h008;
  localparam logic [PCX_AW-1:0] PCX_ADDR_SSMODE = 12'h00C;
  localparam logic [PCX_AW-1:0] PCX_ADDR_CLAIMED = 12'h010;
  // route register 0 fields
  localparam int PCX_B_CP1A = 7;
  localparam int PCX_B_CP1 = 6;
  localparam int PCX_B_CP0A = 5;
  localparam int PCX_B_CP0 = 4;
  localparam int PCX_B_SYSCK = 3;
  localparam int PCX_B_TWOWIRE = 2;
  localparam int PCX_B_SPI = 1;
  localparam int PCX_B_SERIAL = 0;
  // route register 1 fields
  localparam int PCX_B_WPUD = 7;
  localparam int PCX_B_XEN = 6;
  // fixed serial pins
  localparam int PCX_TX_PIN = 4;
  localparam int PCX_RX_PIN = 5;
  // reset values
  localparam logic [7:0] PCX_RST_ROUTE0 = 8'h00;
  localparam logic PCX_RST_WPUD = 1'h0;
  localparam logic PCX_RST_XEN = 1'h0;
  localparam logic [PCX_NPIN-1:0] PCX_RST_INMODE = 20'hFFFFF;
  localparam logic [PCX_NPIN-1:0] PCX_RST_OUTMODE = 20'h00000;
  localparam logic [PCX_NPIN-1:0] PCX_RST_SKIP = 20'h00000;
  localparam logic [1:0] PCX_RST_SSMODE = 2'h0;
  // function codes, listed in falling priority
  typedef enum logic [3:0] {
    FN_TX = 4'h0,
    FN_RX = 4'h1,
    FN_SCK = 4'h2,
    FN_MISO = 4'h3,
    FN_MOSI = 4'h4,
    FN_NSS = 4'h5,
    FN_SDA = 4'h6,
    FN_SCL = 4'h7,
    FN_CP0 = 4'h8,
    FN_CP0A = 4'h9,
    FN_CP1 = 4'hA,
    FN_CP1A = 4'hB,
    FN_SYSCK = 4'hC,
    FN_GPIO = 4'hF
  } pcx_func_t;
  // register decode codes
  typedef enum logic [2:0] {
    RS_NONE = 3'h0,
    RS_ROUTE0 = 3'h1,
    RS_ROUTE1 = 3'h2,
    RS_INMODE = 3'h3,
    RS_OUTMODE = 3'h4,
    RS_SKIP = 3'h5,
    RS_SSMODE = 3'h6,
    RS_CLAIMED = 3'h7
  } pcx_rsel_t;
endpackage : pcx_pkg
